// *** rtl/srtc_top.sv ***
// srtc_top.sv - socket clock: unlock recognition, serial transfer, memory enable gating
// assumes socket pins are asynchronous and cycles last several system clocks
`timescale 1ns/100ps
`include "srtc_regs.svh"

// What this block does
// - an enabled read cycle resets the unlock pointer and starts recognition.
// - each write bit matching the pattern bit at the pointer advances the pointer.
// - a mismatch freezes the pointer and ignores writes until the next read.
// - any read during recognition aborts it and returns the pointer to start.
// - pattern bytes C5 3A A3 5C C5 3A A3 5C, each sent lsb first.
// - before a full match every access outside power failure, recognition writes too, reaches memory.
// - after a match the next 64 cycles move clock bits, memory suppressed.
// - transfer runs bit 0 of register 0 through bit 7 of register 7.
// - time and calendar registers hold bcd values.
// - hours bit 7 high selects twelve-hour mode, low twenty-four.
// - hours bit 5 is pm in twelve-hour mode, else tens bit for 20-23.
// - day bit 4 low lets a low reset pin abort, registers untouched.
// - day bit 5 high stops the oscillator, low lets time advance.
// - reset-gate and oscillator-off bits come up as 1.
// - unused bits in registers 1 to 6 read 0, writes to them ignored.
// - cycles without chip enable leave recognition and transfer undisturbed.
// - on power failure memory chip enable is forced inactive.
// - month lengths follow the calendar with leap years.
// - counts hundredths, seconds, minutes, hours, day, date, month, year.
module srtc_top #(
	parameter int P_HUND_CYC = `SRTC_HUND_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// socket control pins
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_ext_rst_n,
	input wire logic i_pwr_fail,
	// data bit 0
	input wire logic i_serial_data_bit_line,
	output logic o_serial_data_bit_line,
	output logic o_serial_data_bit_line_oe,
	// mated memory
	output logic o_mem_ce_n,
	// status
	output logic o_recog_active,
	output logic o_xfer_active,
	output logic o_osc_running
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic ce_n_s;
	logic oe_n_s;
	logic we_n_s;
	logic ext_rst_n_s;
	logic pf_s;
	logic dq_s;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_r <= 6'h3f;
			sync2_r <= 6'h3f;
		end else begin
			sync1_r <= {i_serial_data_bit_line, i_pwr_fail, i_ext_rst_n, i_we_n, i_oe_n, i_ce_n};
			sync2_r <= sync1_r;
		end
	end

	assign ce_n_s = sync2_r[0];
	assign oe_n_s = sync2_r[1];
	assign we_n_s = sync2_r[2];
	assign ext_rst_n_s = sync2_r[3];
	assign pf_s = sync2_r[4];
	assign dq_s = sync2_r[5];

	////////////////////////////////////////////////////////////////////////
	// cycle detection; a write bit is taken as the write ends
	logic rd_act_r;
	logic wr_act_r;
	logic dq_d_r;
	logic rd_act;
	logic wr_act;
	logic rd_start;
	logic rd_end;
	logic wr_end;
	logic step;

	assign rd_act = !ce_n_s && !oe_n_s && we_n_s && !pf_s;
	assign wr_act = !ce_n_s && !we_n_s && !pf_s;
	assign rd_start = rd_act && !rd_act_r;
	assign rd_end = !rd_act && rd_act_r;
	assign wr_end = !wr_act && wr_act_r;
	assign step = rd_end || wr_end;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_act_r <= 1'b0;
			wr_act_r <= 1'b0;
			dq_d_r <= 1'b0;
		end else begin
			rd_act_r <= rd_act;
			wr_act_r <= wr_act;
			dq_d_r <= dq_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// recognition and transfer sequencer
	srtc_pkg::srtc_state_t state_r;
	srtc_pkg::srtc_state_t state_nxt;
	logic [5:0] ptr_r;
	logic [5:0] ptr_nxt;
	logic [63:0] pattern;
	logic [63:0] cal_img;
	logic [63:0] shadow_r;
	logic [63:0] shadow_nxt;
	logic [7:0] wflag_r;
	logic [7:0] wflag_nxt;
	logic [7:0] load_r;
	logic [7:0] load_nxt;
	logic in_xfer;
	logic pat_bit;
	logic last_step;
	logic abort;

	assign pattern = `SRTC_PATTERN;
	assign pat_bit = pattern[ptr_r];
	assign in_xfer = state_r == srtc_pkg::srtc_st_xfer;
	assign last_step = in_xfer && step && ptr_r == `SRTC_LAST_BIT;
	// gate bit high masks the pin entirely
	assign abort = in_xfer && !ext_rst_n_s && !cal_img[`SRTC_RSTGATE_POS];

	always_comb begin
		state_nxt = state_r;
		ptr_nxt = ptr_r;
		shadow_nxt = shadow_r;
		wflag_nxt = wflag_r;
		load_nxt = 8'h00;
		unique case (state_r)
			srtc_pkg::srtc_st_idle, srtc_pkg::srtc_st_lock: begin
				if (rd_start) begin
					state_nxt = srtc_pkg::srtc_st_match;
					ptr_nxt = 6'h00;
				end
			end
			srtc_pkg::srtc_st_match: begin
				if (rd_start) begin
					ptr_nxt = 6'h00;
				end else if (wr_end && dq_d_r == pat_bit) begin
					ptr_nxt = ptr_r + 6'h01;
					if (ptr_r == `SRTC_LAST_BIT) begin
						state_nxt = srtc_pkg::srtc_st_xfer;
						shadow_nxt = cal_img;
						wflag_nxt = 8'h00;
					end
				end else if (wr_end) begin
					state_nxt = srtc_pkg::srtc_st_lock;
				end
			end
			srtc_pkg::srtc_st_xfer: begin
				if (abort) begin
					state_nxt = srtc_pkg::srtc_st_idle;
				end else if (step) begin
					ptr_nxt = ptr_r + 6'h01;
					if (wr_end) begin
						shadow_nxt[ptr_r] = dq_d_r;
						wflag_nxt[ptr_r[5:3]] = 1'b1;
					end
					if (last_step) begin
						state_nxt = srtc_pkg::srtc_st_idle;
						load_nxt = wflag_nxt;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= srtc_pkg::srtc_st_idle;
			ptr_r <= 6'h00;
			shadow_r <= 64'h0;
			wflag_r <= 8'h00;
			load_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			ptr_r <= ptr_nxt;
			shadow_r <= shadow_nxt;
			wflag_r <= wflag_nxt;
			load_r <= load_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timekeeper; registers written only as a set at the end, so an abort loses nothing
	srtc_calendar #(
		.P_HUND_CYC(P_HUND_CYC)
	) u_calendar (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(load_r),
		.i_load_data(shadow_r),
		.o_cal(cal_img)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs; memory enable lags the pin by three clocks
	logic mem_ce_n_nxt;
	logic dq_oe_nxt;
	logic mem_ce_n_r;
	logic dq_r;
	logic dq_oe_r;
	logic recog_r;
	logic xfer_r;
	logic osc_r;

	assign mem_ce_n_nxt = ce_n_s || pf_s || in_xfer;
	assign dq_oe_nxt = in_xfer && rd_act && !abort;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_ce_n_r <= 1'b1;
			dq_r <= 1'b0;
			dq_oe_r <= 1'b0;
			recog_r <= 1'b0;
			xfer_r <= 1'b0;
			osc_r <= 1'b0;
		end else begin
			mem_ce_n_r <= mem_ce_n_nxt;
			dq_r <= shadow_r[ptr_r];
			dq_oe_r <= dq_oe_nxt;
			recog_r <= state_r == srtc_pkg::srtc_st_match;
			xfer_r <= in_xfer;
			osc_r <= !cal_img[`SRTC_OSCOFF_POS];
		end
	end

	assign o_mem_ce_n = mem_ce_n_r;
	assign o_serial_data_bit_line = dq_r;
	assign o_serial_data_bit_line_oe = dq_oe_r;
	assign o_recog_active = recog_r;
	assign o_xfer_active = xfer_r;
	assign o_osc_running = osc_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	AST_READ_RESTART: assert property (
		rd_start && !in_xfer |=> state_r == srtc_pkg::srtc_st_match && ptr_r == 6'h00)
		else $error("read did not restart recognition");

	AST_MATCH_ADVANCE: assert property (
		state_r == srtc_pkg::srtc_st_match && !rd_start && wr_end
		&& dq_d_r == ((`SRTC_PATTERN >> ptr_r) & 64'h1)
		|=> ptr_r == $past(ptr_r) + 6'h01)
		else $error("matching bit did not advance pointer");

	AST_MISMATCH_LOCK: assert property (
		state_r == srtc_pkg::srtc_st_match && !rd_start && wr_end && dq_d_r != pat_bit
		|=> state_r == srtc_pkg::srtc_st_lock && $stable(ptr_r))
		else $error("mismatch did not freeze recognition");

	AST_LOCK_HOLDS: assert property (
		state_r == srtc_pkg::srtc_st_lock && !rd_start |=> state_r == srtc_pkg::srtc_st_lock)
		else $error("locked sequence left without a read");

	AST_MEM_PASS: assert property (
		!in_xfer && !ce_n_s && !pf_s |=> !o_mem_ce_n)
		else $error("memory access blocked before unlock");

	AST_MEM_BLOCK: assert property (
		in_xfer |=> o_mem_ce_n)
		else $error("memory enabled during transfer");

	AST_PWR_FAIL: assert property (
		pf_s |=> o_mem_ce_n)
		else $error("memory enabled during power failure");

	AST_DQ_ONLY_XFER: assert property (
		o_serial_data_bit_line_oe |-> $past(in_xfer) && $past(rd_act))
		else $error("data bit driven outside a transfer read");

	AST_XFER_END: assert property (
		last_step && !abort |=> state_r == srtc_pkg::srtc_st_idle ##1 load_r == 8'h00)
		else $error("transfer did not end after 64 cycles");

	AST_ABORT: assert property (
		abort |=> state_r == srtc_pkg::srtc_st_idle && load_r == 8'h00)
		else $error("reset pin did not abort without loading");

	AST_GATE_MASKS: assert property (
		in_xfer && cal_img[`SRTC_RSTGATE_POS] && !step |=> in_xfer)
		else $error("gated reset pin disturbed transfer");

	AST_ZERO_BITS: assert property (
		(cal_img & ~`SRTC_CAL_MASK) == 64'h0)
		else $error("unused calendar bit reads one");

	AST_BCD_HUND: assert property (
		cal_img[3:0] <= 4'h9 && cal_img[7:4] <= 4'h9)
		else $error("hundredths not bcd");

	AST_SEC_BCD: assert property (
		cal_img[11:8] <= 4'h9 && cal_img[14:12] <= 3'h5)
		else $error("seconds not bcd");

	AST_PTR_HOLDS: assert property (
		!rd_start && !step |=> $stable(ptr_r))
		else $error("pointer moved without a cycle");

	AST_IDLE_WAITS: assert property (
		state_r == srtc_pkg::srtc_st_idle && !rd_start |=> state_r == srtc_pkg::srtc_st_idle)
		else $error("idle left without a read");

	AST_LOAD_AT_END: assert property (
		load_r != 8'h00 |-> $past(last_step) && !$past(abort))
		else $error("registers loaded outside transfer end");

	AST_ABORT_QUIET: assert property (
		abort |=> !o_serial_data_bit_line_oe)
		else $error("data bit driven after abort");

	AST_OSC_STOP: assert property (
		cal_img[`SRTC_OSCOFF_POS] && load_r == 8'h00 |=> $stable(cal_img))
		else $error("time advanced with oscillator off");

	AST_XFER_READ_STAYS: assert property (
		in_xfer && rd_start && !step && !abort |=> in_xfer && $stable(ptr_r))
		else $error("read disturbed transfer");

	AST_OE_OFF_IDLE: assert property (
		!in_xfer |=> !o_serial_data_bit_line_oe)
		else $error("data bit driven outside transfer");

	COV_UNLOCK: cover property (state_r == srtc_pkg::srtc_st_match ##1 in_xfer);
	COV_XFER_WRITE: cover property (last_step && wflag_nxt != 8'h00);
	COV_ABORT: cover property (abort);
	COV_MISMATCH: cover property (state_r == srtc_pkg::srtc_st_lock);

endmodule // srtc_top

// *** rtl/srtc_regs.svh ***
// srtc_regs.svh - constants of the socket clock: timing, pattern, register layout
// assumes a 10 MHz system clock; included by bare name
`ifndef SRTC_REGS_SVH
`define SRTC_REGS_SVH

// timing
`define SRTC_CLK_NS 100
`define SRTC_HUND_NS 10000000
`define SRTC_HUND_CYC ((`SRTC_HUND_NS + `SRTC_CLK_NS - 1) / `SRTC_CLK_NS)

// serial sequence
`define SRTC_PATTERN 64'h5ca33ac55ca33ac5
`define SRTC_LAST_BIT 6'h3f

// register indices
`define SRTC_IDX_HUND 0
`define SRTC_IDX_SEC 1
`define SRTC_IDX_MIN 2
`define SRTC_IDX_HOUR 3
`define SRTC_IDX_DAY 4
`define SRTC_IDX_DATE 5
`define SRTC_IDX_MONTH 6
`define SRTC_IDX_YEAR 7

// field positions
`define SRTC_HR_MODE_BIT 7
`define SRTC_HR_PM_BIT 5
`define SRTC_RSTGATE_POS 36
`define SRTC_OSCOFF_POS 37

// reset values and implemented-bit masks, register 0 in the low byte
`define SRTC_CAL_RST 64'h0001013100000000
`define SRTC_CAL_MASK 64'hff1f3f37bf7f7fff

`endif

// *** rtl/srtc_pkg.sv ***
// srtc_pkg.sv - types shared by the socket clock modules
// assumes nothing beyond the constants header
package srtc_pkg;

	typedef enum logic [1:0] {
		srtc_st_idle = 2'b00,
		srtc_st_match = 2'b01,
		srtc_st_xfer = 2'b10,
		srtc_st_lock = 2'b11
	} srtc_state_t;

endpackage

// *** rtl/srtc_calendar.sv ***
// srtc_calendar.sv - bcd timekeeper with hundredths prescaler
// assumes load strobes come from the same clock domain
`timescale 1ns/100ps
`include "srtc_regs.svh"

module srtc_calendar #(
	parameter int P_HUND_CYC = `SRTC_HUND_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register load
	input wire logic [7:0] i_load,
	input wire logic [63:0] i_load_data,
	// register image
	output logic [63:0] o_cal
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] cal_r [8];
	logic [7:0] tick_nxt [8];
	logic [31:0] pre_r;
	logic osc_off;
	logic tick;
	localparam logic [63:0] RST_IMG = `SRTC_CAL_RST;
	logic [63:0] msk_img;

	assign msk_img = `SRTC_CAL_MASK;
	assign osc_off = cal_r[`SRTC_IDX_DAY][`SRTC_OSCOFF_POS - 32];
	assign tick = (pre_r == 32'(P_HUND_CYC - 1)) && !osc_off;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_img
			assign o_cal[g*8 +: 8] = cal_r[g];
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pre_r <= 32'h0;
		end else if (osc_off || tick) begin
			pre_r <= 32'h0;
		end else begin
			pre_r <= pre_r + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// two-digit year: 00 counts as leap, right through 2100 is not reached
	always_comb begin
		logic c_sec, c_min, c_hr, c_day, c_mon, c_yr, leap, pm;
		logic [7:0] hr, dmax, hinc;
		c_sec = 1'b0;
		c_min = 1'b0;
		c_hr = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_yr = 1'b0;
		dmax = 8'h31;
		hinc = 8'h00;
		for (int k = 0; k < 8; k++) tick_nxt[k] = cal_r[k];
		hr = cal_r[`SRTC_IDX_HOUR];
		pm = hr[`SRTC_HR_PM_BIT];
		leap = cal_r[7][4] ? (cal_r[7][3:0] == 4'h2 || cal_r[7][3:0] == 4'h6)
			: (cal_r[7][3:0] == 4'h0 || cal_r[7][3:0] == 4'h4 || cal_r[7][3:0] == 4'h8);
		case (cal_r[`SRTC_IDX_MONTH][4:0])
			5'h02: dmax = leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: dmax = 8'h30;
			default: dmax = 8'h31;
		endcase
		c_sec = cal_r[0] == 8'h99;
		tick_nxt[0] = c_sec ? 8'h00 : bcd_inc(cal_r[0]);
		c_min = c_sec && cal_r[1] == 8'h59;
		if (c_sec) tick_nxt[1] = (cal_r[1] == 8'h59) ? 8'h00 : bcd_inc(cal_r[1]);
		c_hr = c_min && cal_r[2] == 8'h59;
		if (c_min) tick_nxt[2] = (cal_r[2] == 8'h59) ? 8'h00 : bcd_inc(cal_r[2]);
		if (hr[`SRTC_HR_MODE_BIT]) begin
			c_day = c_hr && pm && hr[4:0] == 5'h11;
			if (c_hr) begin
				hinc = bcd_inc({3'h0, hr[4:0]});
				tick_nxt[3][4:0] = (hr[4:0] == 5'h12) ? 5'h01 : hinc[4:0];
				if (hr[4:0] == 5'h11) tick_nxt[3][`SRTC_HR_PM_BIT] = !pm;
			end
		end else begin
			c_day = c_hr && hr[5:0] == 6'h23;
			hinc = bcd_inc({2'h0, hr[5:0]});
			if (c_hr) tick_nxt[3][5:0] = c_day ? 6'h00 : hinc[5:0];
		end
		if (c_day) tick_nxt[4][2:0] = (cal_r[4][2:0] == 3'h7) ? 3'h1 : cal_r[4][2:0] + 3'h1;
		c_mon = c_day && cal_r[5] == dmax;
		if (c_day) tick_nxt[5] = c_mon ? 8'h01 : bcd_inc(cal_r[5]);
		c_yr = c_mon && cal_r[6] == 8'h12;
		if (c_mon) tick_nxt[6] = c_yr ? 8'h01 : bcd_inc(cal_r[6]);
		if (c_yr) tick_nxt[7] = (cal_r[7] == 8'h99) ? 8'h00 : bcd_inc(cal_r[7]);
	end

	// a load overrides the same cycle's tick, so a written value is never skipped
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < 8; k++) cal_r[k] <= RST_IMG[k*8 +: 8];
		end else begin
			for (int k = 0; k < 8; k++) begin
				if (i_load[k]) begin
					cal_r[k] <= i_load_data[k*8 +: 8] & msk_img[k*8 +: 8];
				end else if (tick) begin
					cal_r[k] <= tick_nxt[k] & msk_img[k*8 +: 8];
				end
			end
		end
	end

endmodule // srtc_calendar

// *** dv/srtc_ram_model.sv ***
// srtc_ram_model.sv - mated static ram as seen behind the socket
// assumes active-low enables and the bench clock for sampling
`timescale 1ns/100ps

module srtc_ram_model (
	// clock
	input wire logic i_clk,
	// memory control
	input wire logic i_mem_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	// data bit 0 and access count
	output logic o_dq,
	output logic o_dq_en,
	output logic [15:0] o_acc_cnt
);
	logic sel_q = 1'b0;

	////////////////////////////////////////////////////////////////
	// no pull on the line: a read shows a changing value, never a held one
	assign o_dq_en = !i_mem_ce_n && !i_oe_n && i_we_n;
	initial o_dq = 1'b0;
	initial o_acc_cnt = 16'h0;

	always @(posedge i_clk) begin
		sel_q <= !i_mem_ce_n;
		o_dq <= !o_dq;
		if (!i_mem_ce_n && !sel_q) begin
			o_acc_cnt <= o_acc_cnt + 16'h1;
		end
	end
endmodule // srtc_ram_model

// *** dv/srtc_top_tb_top.sv ***
// srtc_top_tb_top.sv - self-checking bench for the socket clock
// assumes the ram model file and the design files are compiled first
`timescale 1ns/100ps

module srtc_top_tb_top;
	localparam logic [63:0] PAT = {8'h5c, 8'ha3, 8'h3a, 8'hc5, 8'h5c, 8'ha3, 8'h3a, 8'hc5};
	localparam logic [63:0] CAL0 = {8'h00, 8'h01, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00, 8'h00};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce_n = 1'b1;
	logic oe_n = 1'b1;
	logic we_n = 1'b1;
	logic ext_rst_n = 1'b1;
	logic pwr_fail = 1'b0;
	logic bdq = 1'b1;
	logic dout, doe, mem_ce_n, recog, xfer, osc, ram_dq, ram_en, oe_q;
	logic [15:0] acc;
	wire dq = doe ? dout : (ram_en ? ram_dq : bdq);
	logic exp_q[$];
	int n_errors = 0;
	int total_checks = 0;
	logic [7:0] hr;
	logic [63:0] wv, ev;

	always #50 clk = !clk;

	srtc_top #(.P_HUND_CYC(4)) uut (
		.i_clk(clk), .i_rst(rst), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_ext_rst_n(ext_rst_n), .i_pwr_fail(pwr_fail), .i_serial_data_bit_line(dq),
		.o_serial_data_bit_line(dout), .o_serial_data_bit_line_oe(doe),
		.o_mem_ce_n(mem_ce_n), .o_recog_active(recog), .o_xfer_active(xfer),
		.o_osc_running(osc)
	);
	srtc_ram_model ram (
		.i_clk(clk), .i_mem_ce_n(mem_ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.o_dq(ram_dq), .o_dq_en(ram_en), .o_acc_cnt(acc)
	);

	////////////////////////////////////////////////////////////////
	task automatic chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_cnt(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one socket cycle; data held past the end so the synced edge still sees it
	task automatic cyc(input logic wr, input logic d);
		@(posedge clk);
		#10;
		ce_n = 1'b0;
		we_n = !wr;
		oe_n = wr;
		bdq = d;
		repeat (6) @(posedge clk);
		#10;
		ce_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic unlock(input int bad);
		logic [15:0] n0;
		n0 = acc;
		cyc(1'b0, 1'b0);
		chk_bit("recog active", 1'b1, recog);
		for (int i = 0; i < 64; i++) begin
			if (i % 8 == 3) begin
				#10 we_n = 1'b0;
				repeat (4) @(posedge clk);
				#10 we_n = 1'b1;
				repeat (3) @(posedge clk);
			end
			cyc(1'b1, PAT[i] ^ (i == bad));
		end
		repeat (4) @(posedge clk);
		chk_cnt("mem accesses", n0 + 16'd65, acc);
		chk_bit("xfer active", bad > 63, xfer);
		chk_bit("recog done", 1'b0, recog);
	endtask

	task automatic xfer_end(input logic [15:0] n0);
		repeat (4) @(posedge clk);
		chk_cnt("mem during xfer", n0, acc);
		chk_bit("xfer done", 1'b0, xfer);
		cyc(1'b0, 1'b0);
		chk_cnt("mem after xfer", n0 + 16'd1, acc);
	endtask

	task automatic xread(input logic [63:0] e);
		logic [15:0] n0;
		n0 = acc;
		for (int i = 0; i < 64; i++) begin
			exp_q.push_back(e[i]);
			cyc(1'b0, 1'b0);
		end
		xfer_end(n0);
	endtask

	task automatic xwrite(input logic [63:0] v);
		logic [15:0] n0;
		n0 = acc;
		for (int i = 0; i < 64; i++) begin
			cyc(1'b1, v[i]);
		end
		xfer_end(n0);
	endtask

	////////////////////////////////////////////////////////////////
	// read bits are judged one cycle after the enable rises, once settled
	always @(posedge clk) begin
		oe_q <= doe;
		if (doe && !oe_q) begin
			if (exp_q.size() == 0) begin
				chk_bit("unexpected read", 1'b0, 1'b1);
			end else begin
				chk_bit("xfer bit", exp_q.pop_front(), dout);
			end
		end
	end

	initial begin
		#5_000_000;
		n_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h60e7));
		repeat (12) @(posedge clk);
		#10 rst = 1'b0;
		repeat (4) @(posedge clk);
		chk_bit("osc after reset", 1'b0, osc);
		unlock(9);
		cyc(1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			cyc(1'b1, PAT[i]);
		end
		chk_bit("recog midway", 1'b1, recog);
		unlock(64);
		xread(CAL0);
		hr = {4'($urandom % 10), 4'($urandom % 10)};
		wv = {8'h96, 8'h02, 8'h29, 8'h25, 8'hb1, 8'hd9, 8'hb0, hr};
		ev = {8'h96, 8'h02, 8'h29, 8'h25, 8'hb1, 8'h59, 8'h30, hr};
		unlock(64);
		xwrite(wv);
		unlock(64);
		xread(ev);
		unlock(64);
		cyc(1'b1, 1'b1);
		cyc(1'b1, 1'b0);
		#10 ext_rst_n = 1'b0;
		repeat (4) @(posedge clk);
		#10 ext_rst_n = 1'b1;
		repeat (4) @(posedge clk);
		chk_bit("xfer after pin reset", 1'b0, xfer);
		unlock(64);
		xread(ev);
		wv[39:32] = 8'h05;
		unlock(64);
		xwrite(wv);
		chk_bit("osc running", 1'b1, osc);
		#10 pwr_fail = 1'b1;
		repeat (4) @(posedge clk);
		wv[15:0] = acc;
		cyc(1'b0, 1'b0);
		chk_cnt("mem in power fail", wv[15:0], acc);
		chk_cnt("queue left", 16'h0, 16'(exp_q.size()));
		end_of_test();
	end
endmodule // srtc_top_tb_top
